// file: inc/mpc_pkg.sv
// shared constants and types for the multiport memory port control
package mpc_pkg;
	// address lines per port
	localparam int ADDR_W = 16;
	// full data bus width, made of two lanes
	localparam int DATA_W = 18;
	// one byte lane, ninth bit included
	localparam int LANE_W = 9;
	// number of byte lanes
	localparam int LANES = 2;
	// lane index of the lower byte
	localparam int LANE_LO = 0;
	// lane index of the upper byte
	localparam int LANE_HI = 1;
	// small default storage; a full array would be 64k words
	localparam int MEM_DEPTH = 256;
	// counter value after any reset
	localparam logic [ADDR_W-1:0] CTR_RESET = 16'h0000;
	// mask after reset lets the counter span the whole range
	localparam logic [ADDR_W-1:0] MASK_RESET = 16'hffff;
	// one step of the burst counter
	localparam logic [ADDR_W-1:0] CTR_STEP = 16'h0001;
	// idle value of the address lines
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 16'h0000;
	// idle value of the data lines
	localparam logic [DATA_W-1:0] DATA_IDLE = 18'h0_0000;
	// operations the master end can issue
	typedef enum logic [2:0] {
		MPC_CMD_WRITE,
		MPC_CMD_READ,
		MPC_CMD_CTR_LOAD,
		MPC_CMD_CTR_ADVANCE,
		MPC_CMD_CTR_CLEAR,
		MPC_CMD_MASK_LOAD,
		MPC_CMD_CTR_READBACK,
		MPC_CMD_MASK_READBACK
	} mpc_cmd_t;
endpackage

// file: inc/mpc_port_if.sv
// pins of one memory port between the master and the device
`timescale 1ns/10ps
interface mpc_port_if;
	// port select pair, both must be active
	logic port_sel_active_low;
	logic port_sel_active_high;
	// high reads, low writes
	logic read_not_write;
	// byte lane selects, active low
	logic lower_byte_sel_n;
	logic upper_byte_sel_n;
	// output enable, acts without a clock
	logic out_en_n;
	// counter and mask controls, active low
	logic burst_ctr_clear_n;
	logic wrap_mask_load_n;
	logic burst_ctr_load_n;
	logic burst_ctr_advance_n;
	logic burst_ctr_readback_n;
	logic wrap_mask_readback_n;
	// one-cycle low pulse on counter wrap
	logic wrap_flag_n;
	// address lines, master and device halves
	logic [mpc_pkg::ADDR_W-1:0] m_addr;
	logic m_addr_oe;
	logic [mpc_pkg::ADDR_W-1:0] d_addr;
	logic d_addr_oe;
	// data lines, device enables per lane
	logic [mpc_pkg::DATA_W-1:0] m_data;
	logic m_data_oe;
	logic [mpc_pkg::DATA_W-1:0] d_data;
	logic [mpc_pkg::LANES-1:0] d_data_oe;
	// documented device end
	modport dev (
		input port_sel_active_low, port_sel_active_high, read_not_write,
		input lower_byte_sel_n, upper_byte_sel_n, out_en_n,
		input burst_ctr_clear_n, wrap_mask_load_n, burst_ctr_load_n,
		input burst_ctr_advance_n, burst_ctr_readback_n, wrap_mask_readback_n,
		input m_addr, m_addr_oe, m_data, m_data_oe,
		output wrap_flag_n, d_addr, d_addr_oe, d_data, d_data_oe
	);
	// external master end
	modport mst (
		output port_sel_active_low, port_sel_active_high, read_not_write,
		output lower_byte_sel_n, upper_byte_sel_n, out_en_n,
		output burst_ctr_clear_n, wrap_mask_load_n, burst_ctr_load_n,
		output burst_ctr_advance_n, burst_ctr_readback_n, wrap_mask_readback_n,
		output m_addr, m_addr_oe, m_data, m_data_oe,
		input wrap_flag_n, d_addr, d_addr_oe, d_data, d_data_oe
	);
endinterface

// file: hdl/mpc_burst_ctr.sv
// burst address counter with wrap mask and priority of operations
`timescale 1ns/10ps
module mpc_burst_ctr #(
	parameter int ADDR_W = mpc_pkg::ADDR_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clear_n,
	input wire logic mask_load_n,
	input wire logic load_n,
	input wire logic advance_n,
	input wire logic [ADDR_W-1:0] addr_in,
	output logic [ADDR_W-1:0] count,
	output logic [ADDR_W-1:0] mask,
	output logic wrap
);
	// whole state of the counter
	typedef struct packed {
		logic [ADDR_W-1:0] count; // current burst address
		logic [ADDR_W-1:0] mask; // wrap mask, ones mark counting bits
		logic wrap; // high for the cycle after a wrap to zero
	} mpc_ctr_state_t;

	mpc_ctr_state_t q; // registered state
	mpc_ctr_state_t next_q; // next state
	logic [ADDR_W-1:0] stepped; // count plus one, cut to width

	// step computed once; bits outside the mask stay frozen
	assign stepped = ADDR_W'(q.count + ADDR_W'(mpc_pkg::CTR_STEP));

	// priority chain of counter and mask operations
	always_comb begin
		next_q = q;
		next_q.wrap = 1'b0;
		// R14: clear ranks first
		if (!clear_n) begin
			// R13: clear to zero
			next_q.count = ADDR_W'(mpc_pkg::CTR_RESET);
		end else if (!mask_load_n) begin
			// R15: mask from address
			// R16: beats counter load
			next_q.mask = addr_in;
		end else if (!load_n) begin
			// R17: load from address
			next_q.count = addr_in;
		end else if (!advance_n) begin
			// R18: advance every edge
			// R22: only when alone
			next_q.count = (q.count & ~q.mask) | (stepped & q.mask);
			// R20: flag wrap to zero
			next_q.wrap = ((q.count & ~q.mask) | (stepped & q.mask)) == '0;
		end
	end

	// R11: master reset asynchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{count: ADDR_W'(mpc_pkg::CTR_RESET), mask: ADDR_W'(mpc_pkg::MASK_RESET),
				wrap: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign count = q.count;
	assign mask = q.mask;
	assign wrap = q.wrap;
endmodule

// file: hdl/mpc_port_ctrl.sv
// device end: control logic of one memory port with its storage
// Contract
// R1: port inputs sampled on the port clock
// R2: lower select low enables lower lane
// R3: lower lane driven needs select and enable
// R4: upper select works like lower select
// R5: selected only with both chip selects active
// R6: master holds enable low to read
// R7: output enable acts without a clock
// R8: write input low writes the array
// R9: master holds write input high reading
// R10: one master reset for all ports
// R11: master reset asynchronous, resets everything
// R12: system resets once after power-up
// R13: counter clear zeroes the burst counter
// R14: counter clear beats other counter operations
// R15: mask load captures the address lines
// R16: mask load wins over counter load
// R17: counter load takes the address lines
// R18: advance low steps counter each edge
// R19: 16-bit address, 18-bit data, two lanes
// R20: wrap flag low one cycle on wrap
// R21: counter readback wins over mask readback
// R22: advance only without higher operations
`timescale 1ns/10ps
module mpc_port_ctrl #(
	// address lines
	parameter int ADDR_W = mpc_pkg::ADDR_W,
	// both lanes
	parameter int DATA_W = mpc_pkg::DATA_W,
	// one lane
	parameter int LANE_W = mpc_pkg::LANE_W,
	// lane count
	parameter int LANES = mpc_pkg::LANES,
	// words stored
	parameter int MEM_DEPTH = mpc_pkg::MEM_DEPTH
) (
	// port clock
	input wire logic clk,
	// shared master reset
	input wire logic rst_b,
	// pins of this port
	mpc_port_if.dev port,
	// observation only
	output logic [ADDR_W-1:0] cur_count,
	output logic [ADDR_W-1:0] cur_mask,
	output logic cur_selected
);
	// index width into the storage
	// a depth of one still needs one index bit,
	// or the part-select below would be empty
	localparam int IDX_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

	// state of the port except the burst counter and mask, storage included
	// storage in the state lets one reset clear it;
	// the cost is a wide reset, fine at this depth
	// a full-size array would want real memory
	typedef struct packed {
		logic [MEM_DEPTH-1:0][DATA_W-1:0] mem; // array words of this port alone
		logic [DATA_W-1:0] rd_data; // read word held for the pins
		logic [LANES-1:0] rd_lane; // lanes that carry read data
		logic rb_act; // address lines carry a readback
		logic [ADDR_W-1:0] rb_val; // value returned on the address lines
		logic selected; // port was selected at the last edge
	} mpc_dev_state_t;

	// one register, one process feeding it
	mpc_dev_state_t q; // registered state
	mpc_dev_state_t next_q; // next state

	// decoded pins
	logic sel; // both chip selects active this cycle
	logic rb_req; // any readback requested
	logic use_ctr; // access address comes from the counter
	logic [LANES-1:0] lane_sel; // lane selects, active high
	// counter wiring
	logic [ADDR_W-1:0] ctr_count; // counter value
	logic [ADDR_W-1:0] ctr_mask; // mask value
	logic ctr_wrap; // wrap pulse from the counter
	// access address and index
	logic [ADDR_W-1:0] eff_addr; // address of this access
	logic [IDX_W-1:0] idx; // storage index of this access

	// pins decoded straight away: the master end
	// registers them, so no extra stage is needed
	// here and a command costs no added latency
	// R5: both selects active
	assign sel = ~port.port_sel_active_low & port.port_sel_active_high;
	// readback ignores chip selects and blocks the data lines
	assign rb_req = ~port.burst_ctr_readback_n | ~port.wrap_mask_readback_n;
	// R2: lower lane select
	// R4: upper lane alike
	assign lane_sel[mpc_pkg::LANE_LO] = ~port.lower_byte_sel_n;
	assign lane_sel[mpc_pkg::LANE_HI] = ~port.upper_byte_sel_n;

	// a burst runs from the counter, so the master
	// may leave the address lines idle meanwhile;
	// a load in the same cycle takes the lines
	// counter addressing only while advancing without a load
	assign use_ctr = ~port.burst_ctr_advance_n & port.burst_ctr_load_n;
	assign eff_addr = use_ctr ? ctr_count : port.m_addr;
	// high address bits beyond the storage fold onto it
	// limitation: small depth makes addresses alias
	assign idx = eff_addr[IDX_W-1:0];

	// counter operations ignore the chip selects:
	// the counter belongs to the port, and loads
	// take the raw address lines when deselected
	// burst counter and wrap mask
	mpc_burst_ctr #(
		.ADDR_W(ADDR_W)
	) u_ctr (
		.clk(clk),
		.rst_b(rst_b),
		.clear_n(port.burst_ctr_clear_n),
		.mask_load_n(port.wrap_mask_load_n),
		.load_n(port.burst_ctr_load_n),
		.advance_n(port.burst_ctr_advance_n),
		.addr_in(port.m_addr),
		.count(ctr_count),
		.mask(ctr_mask),
		.wrap(ctr_wrap)
	);

	// access, read pipeline and readback selection
	// branch order below is the order of service
	always_comb begin
		// hold unless a branch changes it
		next_q = q;
		// kept for observation only
		next_q.selected = sel;
		// lanes released unless a read is taken this edge
		next_q.rd_lane = '0;
		// a readback owns the cycle
		if (sel && !rb_req) begin
			// write cycle
			if (!port.read_not_write) begin
				// R8: write selected lanes
				// masked lanes keep old contents
				for (int k = 0; k < LANES; k++) begin
					// select high leaves the lane alone
					if (lane_sel[k]) begin
						next_q.mem[idx][k*LANE_W +: LANE_W] = port.m_data[k*LANE_W +: LANE_W];
					end
				end
			end else begin
				// read data always registered; lanes gate the drive
				// whole word taken even for one lane
				next_q.rd_data = q.mem[idx];
				// lanes kept for the enable stage
				next_q.rd_lane = lane_sel;
			end
		end
		// readback appears one cycle after the request
		// no idle cycle is inserted before it
		next_q.rb_act = rb_req;
		// R21: counter readback first
		if (!port.burst_ctr_readback_n) begin
			// value before this edge's operation
			next_q.rb_val = ctr_count;
		end else if (!port.wrap_mask_readback_n) begin
			// mask before this edge's load
			next_q.rb_val = ctr_mask;
		end
		// otherwise the last value is held
	end

	// state register; the asynchronous reset clears
	// every port at once, even with its clock gated,
	// so no register waits for an edge to clear
	// R1: sampled on clock
	// R10: single shared reset
	// R11: asynchronous master reset
	// R12: relies on power-up reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// storage is cleared too, so reads after reset are defined
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// data lines always show the held word; enables decide the drive
	// a late output enable shows the last word
	// read, never a fresh access
	assign port.d_data = q.rd_data;
	// R3: select and enable
	// R7: enable acts combinationally
	assign port.d_data_oe = q.rd_lane & {LANES{~port.out_en_n}};
	// address lines answer only for a readback,
	// released in every other cycle
	// R19: 16 and 18 bits
	assign port.d_addr = q.rb_val;
	assign port.d_addr_oe = q.rb_act;
	// flag straight from a counter register, so
	// it is glitch free and one whole cycle long
	// R20: low for one cycle
	assign port.wrap_flag_n = ~ctr_wrap;

	// observation of the counter, mask and select state
	// for a host or a bench; no effect on the
	// pins, so leaving them open is harmless
	assign cur_count = ctr_count;
	assign cur_mask = ctr_mask;
	assign cur_selected = q.selected;
endmodule

// file: hdl/mpc_port_master.sv
// master end: drives one memory port from a simple command port
`timescale 1ns/10ps
module mpc_port_master #(
	parameter int ADDR_W = mpc_pkg::ADDR_W,
	parameter int DATA_W = mpc_pkg::DATA_W,
	parameter int LANES = mpc_pkg::LANES
) (
	input wire logic clk,
	input wire logic rst_b,
	mpc_port_if.mst port,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire mpc_pkg::mpc_cmd_t cmd_op,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [DATA_W-1:0] cmd_data,
	input wire logic [LANES-1:0] cmd_lanes,
	output logic [DATA_W-1:0] rsp_data,
	output logic rsp_valid,
	output logic [ADDR_W-1:0] rb_value,
	output logic rb_valid,
	output logic wrap_seen
);
	// whole state of the master
	typedef struct packed {
		logic sel_n; // drives the active-low select
		logic sel; // drives the active-high select
		logic rnw; // read not write
		logic [LANES-1:0] lane_n; // lane selects, active low
		logic oe_n; // output enable
		logic clr_n; // counter clear
		logic mld_n; // mask load
		logic ld_n; // counter load
		logic adv_n; // counter advance
		logic crb_n; // counter readback
		logic mrb_n; // mask readback
		logic [ADDR_W-1:0] addr; // address driven out
		logic addr_oe; // address drive enable
		logic [DATA_W-1:0] data; // write data driven out
		logic data_oe; // data drive enable
		logic rd_pend; // read issued last cycle
		logic rd_cap; // read data on the pins now
		logic rb_pend; // readback issued last cycle
		logic rb_cap; // readback on the address lines now
		logic [DATA_W-1:0] rsp_data; // captured read word
		logic rsp_valid; // read word pulse
		logic [ADDR_W-1:0] rb_value; // captured readback
		logic rb_valid; // readback pulse
		logic wrap; // wrap seen pulse
	} mpc_mst_state_t;

	mpc_mst_state_t q; // registered state
	mpc_mst_state_t next_q; // next state
	mpc_mst_state_t idle_q; // all pins inactive
	logic take; // command taken this edge

	// the returning cycle owns the shared lines, so no command then
	assign cmd_ready = ~(q.rd_pend | q.rb_pend);
	assign take = cmd_valid & cmd_ready;

	// idle pin values, also the reset value
	always_comb begin
		idle_q = '0;
		idle_q.sel_n = 1'b1;
		idle_q.rnw = 1'b1;
		idle_q.lane_n = '1;
		idle_q.oe_n = 1'b1;
		idle_q.clr_n = 1'b1;
		idle_q.mld_n = 1'b1;
		idle_q.ld_n = 1'b1;
		idle_q.adv_n = 1'b1;
		idle_q.crb_n = 1'b1;
		idle_q.mrb_n = 1'b1;
		idle_q.addr = mpc_pkg::ADDR_IDLE;
		idle_q.data = mpc_pkg::DATA_IDLE;
	end

	// one command per cycle becomes one cycle of pins
	always_comb begin
		next_q = idle_q;
		next_q.rsp_data = q.rsp_data;
		next_q.rb_value = q.rb_value;
		next_q.rd_cap = q.rd_pend;
		next_q.rb_cap = q.rb_pend;
		// R6: enable low reading
		next_q.oe_n = ~q.rd_pend;
		next_q.rsp_valid = q.rd_cap;
		next_q.rb_valid = q.rb_cap;
		next_q.wrap = ~port.wrap_flag_n;
		if (q.rd_cap) begin
			next_q.rsp_data = port.d_data;
		end
		if (q.rb_cap) begin
			next_q.rb_value = port.d_addr;
		end
		if (take) begin
			case (cmd_op)
				mpc_pkg::MPC_CMD_WRITE, mpc_pkg::MPC_CMD_READ: begin
					// R5: drive both selects
					next_q.sel_n = 1'b0;
					next_q.sel = 1'b1;
					next_q.lane_n = ~cmd_lanes;
					next_q.addr = cmd_addr;
					next_q.addr_oe = 1'b1;
					// R8: write low
					// R9: read high
					next_q.rnw = (cmd_op == mpc_pkg::MPC_CMD_READ);
					next_q.data = cmd_data;
					next_q.data_oe = (cmd_op == mpc_pkg::MPC_CMD_WRITE);
					next_q.rd_pend = (cmd_op == mpc_pkg::MPC_CMD_READ);
				end
				mpc_pkg::MPC_CMD_CTR_LOAD: begin
					next_q.ld_n = 1'b0;
					next_q.addr = cmd_addr;
					next_q.addr_oe = 1'b1;
				end
				mpc_pkg::MPC_CMD_MASK_LOAD: begin
					next_q.mld_n = 1'b0;
					next_q.addr = cmd_addr;
					next_q.addr_oe = 1'b1;
				end
				mpc_pkg::MPC_CMD_CTR_ADVANCE: begin
					next_q.adv_n = 1'b0;
				end
				mpc_pkg::MPC_CMD_CTR_CLEAR: begin
					next_q.clr_n = 1'b0;
				end
				mpc_pkg::MPC_CMD_CTR_READBACK: begin
					next_q.crb_n = 1'b0;
					next_q.rb_pend = 1'b1;
				end
				mpc_pkg::MPC_CMD_MASK_READBACK: begin
					next_q.mrb_n = 1'b0;
					next_q.rb_pend = 1'b1;
				end
				default: begin
					next_q.rd_pend = 1'b0;
				end
			endcase
		end
	end

	// R1: driven on clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{sel_n: 1'b1, rnw: 1'b1, lane_n: '1, oe_n: 1'b1, clr_n: 1'b1,
				mld_n: 1'b1, ld_n: 1'b1, adv_n: 1'b1, crb_n: 1'b1, mrb_n: 1'b1,
				default: '0};
		end else begin
			q <= next_q;
		end
	end

	// pins straight from the registers
	assign port.port_sel_active_low = q.sel_n;
	assign port.port_sel_active_high = q.sel;
	assign port.read_not_write = q.rnw;
	assign port.lower_byte_sel_n = q.lane_n[mpc_pkg::LANE_LO];
	assign port.upper_byte_sel_n = q.lane_n[mpc_pkg::LANE_HI];
	assign port.out_en_n = q.oe_n;
	assign port.burst_ctr_clear_n = q.clr_n;
	assign port.wrap_mask_load_n = q.mld_n;
	assign port.burst_ctr_load_n = q.ld_n;
	assign port.burst_ctr_advance_n = q.adv_n;
	assign port.burst_ctr_readback_n = q.crb_n;
	assign port.wrap_mask_readback_n = q.mrb_n;
	assign port.m_addr = q.addr;
	assign port.m_addr_oe = q.addr_oe;
	assign port.m_data = q.data;
	assign port.m_data_oe = q.data_oe;
	assign rsp_data = q.rsp_data;
	assign rsp_valid = q.rsp_valid;
	assign rb_value = q.rb_value;
	assign rb_valid = q.rb_valid;
	assign wrap_seen = q.wrap;
endmodule

// file: testbench/mpc_checker.sv
// pin-level checks between the master end and the device end
`timescale 1ns/10ps
module mpc_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic port_sel_active_low,
	input wire logic port_sel_active_high,
	input wire logic read_not_write,
	input wire logic lower_byte_sel_n,
	input wire logic upper_byte_sel_n,
	input wire logic out_en_n,
	input wire logic burst_ctr_clear_n,
	input wire logic burst_ctr_advance_n,
	input wire logic burst_ctr_readback_n,
	input wire logic wrap_mask_readback_n,
	input wire logic wrap_flag_n,
	input wire logic [mpc_pkg::ADDR_W-1:0] d_addr,
	input wire logic d_addr_oe,
	input wire logic [mpc_pkg::LANES-1:0] d_data_oe
);
	// single clock domain, so one default for all
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// selected read with no readback stealing the cycle
	sequence s_read;
		!port_sel_active_low && port_sel_active_high && read_not_write
			&& burst_ctr_readback_n && wrap_mask_readback_n;
	endsequence
	// clear, then counter readback at once
	sequence s_clear_rb;
		!burst_ctr_clear_n ##1 !burst_ctr_readback_n;
	endsequence
	a_oe_release: assert property (out_en_n |-> d_data_oe == 2'h0)
		else $error("data driven with output enable high");
	a_lane_drive: assert property (s_read ##1 !out_en_n |->
		d_data_oe == ~{$past(upper_byte_sel_n), $past(lower_byte_sel_n)})
		else $error("read lanes differ from byte selects");
	a_lower_cause: assert property (d_data_oe[0] |->
		$past(!lower_byte_sel_n && read_not_write))
		else $error("lower lane driven without lower select read");
	a_upper_cause: assert property (d_data_oe[1] |-> $past(!upper_byte_sel_n))
		else $error("upper lane driven without upper select");
	a_sel_needed: assert property (d_data_oe != 2'h0 |->
		$past(!port_sel_active_low && port_sel_active_high))
		else $error("data driven for unselected port");
	a_write_quiet: assert property (!read_not_write |=> d_data_oe == 2'h0)
		else $error("data driven after a write cycle");
	a_clear_zero: assert property (s_clear_rb |=> d_addr_oe && d_addr == 16'h0000)
		else $error("counter not zero after clear");
	a_wrap_single: assert property (!wrap_flag_n |=> wrap_flag_n)
		else $error("wrap flag low longer than one cycle");
	a_wrap_cause: assert property ($fell(wrap_flag_n) |-> $past(!burst_ctr_advance_n))
		else $error("wrap flag without a counter step");
	a_readback_lat: assert property (
		!burst_ctr_readback_n || !wrap_mask_readback_n |=> d_addr_oe)
		else $error("readback value missing");
endmodule

// file: testbench/testbench.sv
// bench: master and device ends joined, plus a bare device end
`timescale 1ns/10ps
module testbench;
	logic clk;
	logic rst_b;
	// command port of the master end
	logic cmd_valid;
	logic cmd_ready;
	mpc_pkg::mpc_cmd_t cmd_op;
	logic [15:0] cmd_addr;
	logic [17:0] cmd_data;
	logic [1:0] cmd_lanes;
	logic [17:0] rsp_data;
	logic rsp_valid;
	logic [15:0] rb_value;
	logic rb_valid;
	logic wrap_seen;
	logic sel_seen; // select state of the joined end
	// counter views of both device ends
	logic [15:0] cnt, msk, cnt2, msk2;
	// bench-driven counter pins of the bare end
	logic [3:0] b_ops;
	logic [1:0] b_rb;
	logic [15:0] b_addr;
	int mismatches, n_checks, n_wraps;
	mpc_port_if bus();
	mpc_port_if bare();
	mpc_port_ctrl i_mpc_port_ctrl (.clk(clk), .rst_b(rst_b), .port(bus),
		.cur_count(cnt), .cur_mask(msk), .cur_selected(sel_seen));
	// second end: counter pins at once, which the master never does
	mpc_port_ctrl i_mpc_port_ctrl_2 (.clk(clk), .rst_b(rst_b), .port(bare),
		.cur_count(cnt2), .cur_mask(msk2), .cur_selected());
	mpc_port_master i_mpc_port_master (.clk(clk), .rst_b(rst_b), .port(bus),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_lanes(cmd_lanes),
		.rsp_data(rsp_data), .rsp_valid(rsp_valid), .rb_value(rb_value),
		.rb_valid(rb_valid), .wrap_seen(wrap_seen));
	mpc_checker i_mpc_checker (.clk(clk), .rst_b(rst_b),
		.port_sel_active_low(bus.port_sel_active_low),
		.port_sel_active_high(bus.port_sel_active_high),
		.read_not_write(bus.read_not_write), .out_en_n(bus.out_en_n),
		.lower_byte_sel_n(bus.lower_byte_sel_n), .upper_byte_sel_n(bus.upper_byte_sel_n),
		.burst_ctr_clear_n(bus.burst_ctr_clear_n), .wrap_flag_n(bus.wrap_flag_n),
		.burst_ctr_advance_n(bus.burst_ctr_advance_n), .d_addr(bus.d_addr),
		.burst_ctr_readback_n(bus.burst_ctr_readback_n), .d_addr_oe(bus.d_addr_oe),
		.wrap_mask_readback_n(bus.wrap_mask_readback_n), .d_data_oe(bus.d_data_oe));
	// bare end mirrors the access pins except the address lines, which come from b_addr, so it still sees real traffic
	assign {bare.port_sel_active_low, bare.port_sel_active_high, bare.read_not_write,
		bare.lower_byte_sel_n, bare.upper_byte_sel_n, bare.out_en_n, bare.m_data,
		bare.m_data_oe, bare.m_addr_oe} = {bus.port_sel_active_low,
		bus.port_sel_active_high, bus.read_not_write, bus.lower_byte_sel_n,
		bus.upper_byte_sel_n, bus.out_en_n, bus.m_data, bus.m_data_oe, bus.m_addr_oe};
	assign {bare.burst_ctr_clear_n, bare.wrap_mask_load_n, bare.burst_ctr_load_n,
		bare.burst_ctr_advance_n, bare.burst_ctr_readback_n, bare.wrap_mask_readback_n,
		bare.m_addr} = {b_ops, b_rb, b_addr};
	// 125 MHz clock
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// wrap pulses seen by the master end
	always @(posedge clk) begin
		if (wrap_seen === 1'h1) begin
			n_wraps <= n_wraps + 1;
		end
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [17:0] e, input logic [17:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// bounded wait ran out
	task automatic hang;
		mismatches++;
		$display("[FAIL] handshake expected 1 seen timeout");
		finish_test();
	endtask
	// present one command, return at the edge that takes it
	task automatic cmd(input mpc_pkg::mpc_cmd_t op, input logic [15:0] a,
		input logic [17:0] d, input logic [1:0] l);
		int i;
		cmd_valid <= 1'h1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_lanes <= l;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (cmd_ready !== 1'h1 && i < 20);
		if (i >= 20) hang();
	endtask
	// release the command, then await an answer or the device edge
	task automatic done(input logic w);
		int i;
		cmd_valid <= 1'h0;
		i = 0;
		if (w) begin
			do begin
				@(posedge clk);
				i++;
			end while (rsp_valid !== 1'h1 && rb_valid !== 1'h1 && i < 20);
			if (i >= 20) hang();
		end else begin
			// second edge: device edge results settled, stimulus stays on edges
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic go(input mpc_pkg::mpc_cmd_t op, input logic [15:0] a,
		input logic [17:0] d, input logic [1:0] l, input logic w);
		cmd(op, a, d, l);
		done(w);
	endtask
	// drive counter pins of the bare end for n edges
	task automatic drive(input logic [3:0] ops, input logic [1:0] rb,
		input logic [15:0] ad, input int n);
		@(posedge clk);
		b_ops <= ops;
		b_rb <= rb;
		b_addr <= ad;
		repeat (n) @(posedge clk);
		b_ops <= 4'hf;
		b_rb <= 2'h3;
		#1;
	endtask
	// byte lanes written and read apart
	task automatic t_lanes;
		go(mpc_pkg::MPC_CMD_WRITE, 16'h0005, 18'h3_c1a5, 2'h3, 1'h0);
		chk("selected", 18'h0_0001, 18'(sel_seen));
		go(mpc_pkg::MPC_CMD_READ, 16'h0005, 18'h0_0000, 2'h3, 1'h1);
		chk("full word", 18'h3_c1a5, rsp_data);
		go(mpc_pkg::MPC_CMD_WRITE, 16'h0005, 18'h0_0000, 2'h1, 1'h0);
		go(mpc_pkg::MPC_CMD_WRITE, 16'h0005, 18'h3_ffff, 2'h2, 1'h0);
		go(mpc_pkg::MPC_CMD_READ, 16'h0005, 18'h0_0000, 2'h3, 1'h1);
		chk("lane writes", 18'h3_fe00, rsp_data);
		go(mpc_pkg::MPC_CMD_READ, 16'h0005, 18'h0_0000, 2'h2, 1'h1);
		chk("upper lane", 18'h0_01ff, 18'(rsp_data[17:9]));
	endtask
	// load, mask, step, wrap and clear through the master
	task automatic t_counter;
		go(mpc_pkg::MPC_CMD_CTR_LOAD, 16'h00fe, 18'h0_0000, 2'h0, 1'h0);
		chk("load", 18'h0_00fe, 18'(cnt));
		chk("not selected", 18'h0_0000, 18'(sel_seen));
		go(mpc_pkg::MPC_CMD_MASK_LOAD, 16'h00ff, 18'h0_0000, 2'h0, 1'h0);
		chk("mask", 18'h0_00ff, 18'(msk));
		go(mpc_pkg::MPC_CMD_CTR_ADVANCE, 16'h0000, 18'h0_0000, 2'h0, 1'h0);
		chk("step", 18'h0_00ff, 18'(cnt));
		go(mpc_pkg::MPC_CMD_CTR_ADVANCE, 16'h0000, 18'h0_0000, 2'h0, 1'h0);
		go(mpc_pkg::MPC_CMD_MASK_READBACK, 16'h0000, 18'h0_0000, 2'h0, 1'h1);
		chk("mask back", 18'h0_00ff, 18'(rb_value));
		chk("wrap pulses", 18'h0_0001, 18'(n_wraps));
		go(mpc_pkg::MPC_CMD_CTR_LOAD, 16'h0033, 18'h0_0000, 2'h0, 1'h0);
		cmd(mpc_pkg::MPC_CMD_CTR_CLEAR, 16'h0000, 18'h0_0000, 2'h0);
		cmd(mpc_pkg::MPC_CMD_CTR_READBACK, 16'h0000, 18'h0_0000, 2'h0);
		done(1'h1);
		chk("cleared", 18'h0_0000, 18'(rb_value));
		go(mpc_pkg::MPC_CMD_CTR_LOAD, 16'h0033, 18'h0_0000, 2'h0, 1'h0);
	endtask
	// operations raised together on the bare end
	task automatic t_prio;
		drive(4'he, 2'h3, 16'h0000, 3);
		chk("held step", 18'h0_0003, 18'(cnt2));
		drive(4'h0, 2'h3, 16'h1234, 1);
		chk("clear wins", 18'h0_0000, 18'(cnt2));
		chk("mask kept", 18'h0_ffff, 18'(msk2));
		drive(4'h9, 2'h3, 16'h00f0, 1);
		chk("mask wins", 18'h0_00f0, 18'(msk2));
		chk("load ignored", 18'h0_0000, 18'(cnt2));
		drive(4'hc, 2'h3, 16'h0012, 1);
		chk("no step", 18'h0_0012, 18'(cnt2));
		drive(4'hf, 2'h0, 16'h0000, 1);
		chk("count back", 18'h0_0012, 18'(bare.d_addr));
	endtask
	// reset dropped between edges clears both ends at once
	task automatic t_mreset;
		@(posedge clk);
		#2;
		rst_b = 1'h0;
		#1;
		chk("count", 18'h0_0000, 18'(cnt));
		chk("mask", 18'h0_ffff, 18'(msk));
		chk("count 2", 18'h0_0000, 18'(cnt2));
		chk("mask 2", 18'h0_ffff, 18'(msk2));
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
	endtask
	// main sequence
	initial begin
		rst_b = 1'h0;
		cmd_valid = 1'h0;
		cmd_op = mpc_pkg::MPC_CMD_WRITE;
		cmd_addr = 16'h0000;
		cmd_data = 18'h0_0000;
		cmd_lanes = 2'h0;
		b_ops = 4'hf;
		b_rb = 2'h3;
		b_addr = 16'h0000;
		mismatches = 0;
		n_checks = 0;
		n_wraps = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		chk("reset mask", 18'h0_ffff, 18'(msk));
		t_lanes();
		t_counter();
		t_prio();
		t_mreset();
		finish_test();
	end
endmodule
